// ---- test/modbus_codec_checker_assertions.sv ----
// port checker for the modbus request codec
`timescale 1ns/1ps
`include "modbus_codec_regs.vh"
module modbus_codec_checker (
    input wire core_clk,
    input wire rst,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire [7:0] txData,
    input wire txValid,
    input wire txReady,
    input wire rxValid,
    input wire rxLast
);
    // bytes sent in this job, cleared when the reply ends
    reg [3:0] txIdx;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    always @(posedge core_clk) begin
        if (rst || (rxValid && rxLast))
            txIdx <= 4'h0;
        else if (txValid && txReady)
            txIdx <= txIdx + 4'h1;
    end
    sequence s_wtake;
        s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    endsequence
    sequence s_rtake;
        s_axi_arready && s_axi_arvalid;
    endsequence
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready too long");
    a_b_answer: assert property (s_wtake |=> s_axi_bvalid)
        else $error("no write answer");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_r_answer: assert property (s_rtake |-> ##2 s_axi_rvalid)
        else $error("read answer late");
    a_gap_slverr: assert property (s_axi_awready && s_axi_awvalid && s_axi_wvalid &&
        s_axi_awaddr > 12'h010 && s_axi_awaddr < 12'h400 |=> s_axi_bresp == `AXI_SLVERR)
        else $error("hole write not refused");
    a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("line byte changed while waiting");
    a_line_code: assert property (txValid && txIdx == 4'h1 |-> !txData[`FC_WIDE_BIT])
        else $error("width bit on the line");
    a_frame_len: assert property (txValid |-> txIdx < 4'h8)
        else $error("request frame too long");
endmodule // modbus_codec_checker
bind modbus_master_request_codec modbus_codec_checker chk (.*);

// ---- test/modbus_slave_model.sv ----
// behavioural remote slave on the byte link of the codec
`timescale 1ns/1ps
module modbus_slave_model (
    input wire core_clk,
    input wire [7:0] txData,
    input wire txValid,
    output logic txReady,
    output logic [7:0] rxData,
    output logic rxValid,
    output logic rxLast,
    input wire slow,
    input wire echo,
    input wire [3:0] reqLen
);
    logic [7:0] got [$];
    logic [7:0] rp [$];
    logic [7:0] ans [$];
    initial begin
        txReady = 1'b0;
        rxValid = 1'b0;
        rxLast = 1'b0;
        rxData = 8'hA5;
        forever begin
            do begin
                @(posedge core_clk);
                if (txValid && txReady)
                    got.push_back(txData);
                txReady <= (got.size() < reqLen) && (!slow || !txReady);
            end while (got.size() < reqLen);
            // wide variants are answered like narrow ones: no width bit on the line
            if (echo)
                ans = got;
            else
                ans = rp;
            repeat (3) @(posedge core_clk);
            foreach (ans[k]) begin
                rxData <= ans[k];
                rxValid <= 1'b1;
                rxLast <= (k == ans.size() - 1);
                @(posedge core_clk);
                if (slow) begin
                    rxValid <= 1'b0;
                    rxLast <= 1'b0;
                    rxData <= ~ans[k];
                    @(posedge core_clk);
                end
            end
            rxValid <= 1'b0;
            rxLast <= 1'b0;
            rxData <= ~rxData;
            while (got.size() != 0)
                @(posedge core_clk);
        end
    end
endmodule // modbus_slave_model

// ---- test/tb_modbus_master_request_codec.sv ----
// self-checking bench of the modbus request codec
`timescale 1ns/1ps
`include "modbus_codec_regs.vh"
module tb_modbus_master_request_codec;
    logic core_clk, rst, slow, echo, txValid, txReady, rxValid, rxLast;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, lfsr, rd;
    logic [3:0] s_axi_wstrb, reqLen;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] txData, rxData;
    logic [15:0] expMem [0:39];
    bit known [0:39];
    logic [7:0] req [$];
    int errors, check_count, cycles;
    modbus_master_request_codec uut (.*);
    modbus_slave_model sl (.*);
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            close_out();
        end
    end
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            // late bready so the response is seen waiting once
            if (!s_axi_bready) s_axi_bready <= !s_axi_awvalid;
        end while (!(s_axi_bvalid && s_axi_bready));
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRead(input logic [11:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic job(input logic [7:0] fc, input logic [15:0] a, input logic [31:0] v,
            input logic [1:0] md, input int nd, input bit ex);
        logic [7:0] sa, base;
        int len, st, n;
        bit rej, xe, eb;
        sa = rnd();
        base = fc & 8'hBF;
        if (base != 8'h08)
            a = {rnd(), rnd()};
        rej = fc[6] && !(md == 2'b11 && (base == 8'h03 || base == 8'h06));
        if (base < 8'h03)
            rej |= v[31:16] == 0 || v[31:16] > (md[0] ? 2008 : 2040);
        else if (base < 8'h05)
            rej |= v[31:16] == 0 || v[31:16] > (md[0] ? 125 : 127);
        else if (base == 8'h08)
            rej |= a != 0;
        else if (!(base inside {8'h05, 8'h06, 8'h07, 8'h0B, 8'h0C}))
            rej = 1;
        xe = ex && !rej && base != 8'h08;
        eb = ex && !rej && base == 8'h08;
        len = (base == 8'h07 || base > 8'h0A) ? 2 : (fc == 8'h46 ? 8 : 6);
        st = (base < 8'h05 || base == 8'h0C) ? 3 : 2;
        req = {sa, base, a[15:8], a[7:0], v[31:24], v[23:16], v[15:8], v[7:0]};
        req = req[0:len-1];
        @(posedge core_clk);
        sl.got.delete();
        slow <= ~slow;
        echo <= base == 8'h08 && !eb;
        reqLen <= rej ? 4'h1 : len[3:0];
        sl.rp = {sa, base | {xe, 7'h00}};
        if (xe || st == 3)
            sl.rp.push_back(xe ? 8'h02 : nd[7:0]);
        if (!xe)
            repeat (nd) sl.rp.push_back(rnd());
        if (eb) begin
            sl.rp = req;
            sl.rp[len-1] = ~req[len-1];
        end
        axiWrite(`REG_REQ0, {a[7:0], a[15:8], fc, sa});
        axiWrite(`REG_REQ1, {v[7:0], v[15:8], v[23:16], v[31:24]});
        axiWrite(`REG_CTRL, {29'h0, md, 1'b1});
        n = 0;
        do begin
            axiRead(`REG_STATUS);
            n++;
        end while (rd[1:0] !== 2'b10 && n < 300);
        check(rd[15:0], {xe ? 8'h02 : 8'h00, 3'b000, eb, xe, rej, 2'b10});
        check(sl.got.size(), rej ? 0 : len);
        foreach (sl.got[k])
            check(sl.got[k], req[k]);
        for (int d = 0; d < nd && !rej && !xe; d++) begin
            if (base < 8'h03) begin
                if (d % 2)
                    expMem[d / 2][15:8] = sl.rp[st + d];
                else
                    expMem[d / 2] = {8'h00, sl.rp[st + d]};
                known[d / 2] = 1;
            end else if (base == 8'h07)
                expMem[0][15:8] = sl.rp[2];
            else if (base < 8'h05 || base > 8'h0A) begin
                if (d % 2)
                    expMem[d / 2][7:0] = sl.rp[st + d];
                else
                    expMem[d / 2][15:8] = sl.rp[st + d];
                known[d / 2] |= d % 2;
            end
        end
        for (int w = 0; w < 40; w++) begin
            if (known[w]) begin
                axiRead(`REPLY_BASE + 12'(4 * w));
                check(rd[15:0], expMem[w]);
            end
        end
    endtask
    initial begin
        rst = 1'b1;
        lfsr = 32'h2AA3;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hF;
        {slow, echo} = 2'h0;
        reqLen = 4'h1;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        axiRead(`REG_STATUS);
        check(rd, 32'h0);
        axiRead(`REG_REQ1);
        check(rd, 32'h0);
        axiWrite(`REG_CTRL, 32'h6);
        axiRead(`REG_CTRL);
        check(rd, 32'h6);
        axiWrite(12'h100, 32'hFFFFFFFF);
        check(resp, `AXI_SLVERR);
        axiRead(12'h100);
        check(resp, `AXI_SLVERR);
        check(rd, 32'h0);
        job(8'h01, 0, 32'h00110000, 0, 3, 0);
        job(8'h02, 0, 32'h00010000, 1, 1, 0);
        job(8'h01, 0, 32'h07F80000, 0, 2, 0);
        job(8'h02, 0, 32'h07F90000, 0, 0, 0);
        job(8'h01, 0, 32'h07D90000, 1, 0, 0);
        job(8'h02, 0, 32'h07D80000, 1, 2, 0);
        job(8'h03, 0, 32'h007F0000, 0, 4, 0);
        job(8'h04, 0, 32'h00800000, 0, 0, 0);
        job(8'h04, 0, 32'h007D0000, 1, 6, 0);
        job(8'h03, 0, 32'h007E0000, 1, 0, 0);
        job(8'h03, 0, 32'h0, 0, 0, 0);
        job(8'h43, 0, 32'h00020000, 3, 8, 0);
        job(8'h43, 0, 32'h00020000, 1, 0, 0);
        job(8'h46, 0, {rnd(), rnd(), rnd(), rnd()}, 3, 0, 0);
        job(8'h05, 0, 32'hFF000000, 0, 0, 0);
        job(8'h06, 0, {rnd(), rnd(), 16'h0}, 0, 0, 0);
        job(8'h07, 0, 0, 0, 1, 0);
        job(8'h08, 0, {rnd(), rnd(), 16'h0}, 0, 0, 0);
        job(8'h08, 0, 32'h00010000, 0, 0, 1);
        job(8'h08, 16'h0001, 0, 0, 0, 0);
        job(8'h0B, 0, 0, 0, 4, 0);
        job(8'h0C, 0, 0, 0, 70, 0);
        job(8'h03, 0, 32'h00050000, 0, 0, 1);
        job(8'h10, 0, 32'h00010000, 0, 0, 0);
        close_out();
    end
endmodule // tb_modbus_master_request_codec

// ---- verilog/modbus_codec_regs.vh ----
// register map, field positions and limits of the modbus request codec
`ifndef MODBUS_CODEC_REGS_VH
`define MODBUS_CODEC_REGS_VH

`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_REQ0 12'h008
`define REG_REQ1 12'h00C
`define REG_WORDS 12'h010
`define REPLY_BASE 12'h400

`define CTRL_START 0
`define CTRL_ASCII 1
`define CTRL_WIDE 2

`define ST_BUSY 0
`define ST_DONE 1
`define ST_REJECT 2
`define ST_EXCEPT 3
`define ST_ECHO_BAD 4
`define ST_CODE_LSB 8

`define FC_READ_COILS 8'h01
`define FC_READ_INPUTS 8'h02
`define FC_READ_HOLDING 8'h03
`define FC_READ_INREGS 8'h04
`define FC_WRITE_COIL 8'h05
`define FC_WRITE_REG 8'h06
`define FC_EXC_STATUS 8'h07
`define FC_LOOPBACK 8'h08
`define FC_EVENT_COUNT 8'h0B
`define FC_EVENT_LOG 8'h0C
`define FC_WIDE_BIT 6
`define FC_ERROR_BIT 7

`define BITS_MAX_BIN 16'd2040
`define BITS_MAX_ASCII 16'd2008
`define REGS_MAX_BIN 16'd127
`define REGS_MAX_ASCII 16'd125
`define DIAG_ECHO_SUB 16'h0000

`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// ---- verilog/modbus_master_request_codec.v ----
// modbus master job handler: request encoder, reply unpacker, axi4-lite registers
//
// Summary of operation
// - ascii plus wide option enables 32-bit registers
// - function bit 6 selects 32-bit width
// - width bit stripped from transmitted function code
// - addresses and coil states sent unchecked
// - bit count 1..2040 binary, 1..2008 ascii
// - register count 1..127 binary, 1..125 ascii
// - bit bytes fill low then high byte
// - unpaired last bit byte gets 00h high
// - single register value sent without restriction
// - exception status request is address plus code
// - exception bits to high byte, low kept
// - loopback reply never written to buffer
// - loopback subcode must be 0000, any value
// - event counter: status word then counter
// - line words travel high byte first
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "modbus_codec_regs.vh"
module modbus_master_request_codec (
    input wire core_clk,
    input wire rst,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [7:0] txData,
    output reg txValid,
    input wire txReady,
    input wire [7:0] rxData,
    input wire rxValid,
    input wire rxLast
);
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_CHECK = 4'b0010;
    localparam [3:0] S_SEND = 4'b0100;
    localparam [3:0] S_RECV = 4'b1000;

    function isBitRead;
        input [7:0] fc;
        isBitRead = (fc == `FC_READ_COILS) || (fc == `FC_READ_INPUTS);
    endfunction

    function isRegRead;
        input [7:0] fc;
        isRegRead = (fc == `FC_READ_HOLDING) || (fc == `FC_READ_INREGS);
    endfunction

    reg [3:0] state;
    reg asciiMode;
    reg wideEnable;
    reg [31:0] request_buffer0;
    reg [31:0] request_buffer1;
    reg busy;
    reg done;
    reg rejected;
    reg excepted;
    reg echoBad;
    reg [7:0] excCode;
    reg [8:0] wordsStored;
    reg startReq;
    reg [7:0] lineFc;
    reg [3:0] txLen;
    reg [3:0] txIdx;
    reg [9:0] rxIdx;
    reg rdPending;
    reg [11:0] rdAddrHeld;
    reg storeEn;
    reg storeLo;
    reg storeHi;
    reg [7:0] storeAddr;
    reg [15:0] storeData;

    wire [15:0] replyWord;
    wire [7:0] function_code_field = request_buffer0[15:8];
    wire [7:0] baseFc = function_code_field & 8'hBF;
    wire wideSel = function_code_field[`FC_WIDE_BIT];
    wire [15:0] countField = {request_buffer1[7:0], request_buffer1[15:8]};
    wire [15:0] addrField = {request_buffer0[23:16], request_buffer0[31:24]};
    wire [7:0] storeIdx = s_axi_araddr[9:2];
    wire axiWrite = s_axi_awready && s_axi_awvalid && s_axi_wready && s_axi_wvalid;
    wire axiRead = s_axi_arready && s_axi_arvalid;

    modbus_reply_store replyStore (
        .core_clk(core_clk),
        .wrEn(storeEn),
        .wrLo(storeLo),
        .wrHi(storeHi),
        .wrAddr(storeAddr),
        .wrData(storeData),
        .rdAddr(storeIdx),
        .rdData(replyWord)
    );

    // request byte n as laid out in the request buffer
    function [7:0] reqByte;
        input [3:0] n;
        input [31:0] w0;
        input [31:0] w1;
        input [7:0] fcOut;
        begin
            case (n)
                4'd0: reqByte = w0[7:0];
                4'd1: reqByte = fcOut;
                4'd2: reqByte = w0[23:16];
                4'd3: reqByte = w0[31:24];
                4'd4: reqByte = w1[7:0];
                4'd5: reqByte = w1[15:8];
                4'd6: reqByte = w1[23:16];
                4'd7: reqByte = w1[31:24];
                default: reqByte = 8'h00;
            endcase
        end
    endfunction

    // acceptance check of the held request
    reg checkOk;
    reg [3:0] checkLen;
    reg wideOk;
    always @* begin
        wideOk = asciiMode && wideEnable;
        checkOk = 1'b1;
        checkLen = 4'd6;
        if (wideSel && !(wideOk && (baseFc == `FC_READ_HOLDING || baseFc == `FC_WRITE_REG))) begin
            checkOk = 1'b0;
        end
        if (isBitRead(baseFc)) begin
            if (countField == 16'h0000 ||
                countField > (asciiMode ? `BITS_MAX_ASCII : `BITS_MAX_BIN)) begin
                checkOk = 1'b0;
            end
        end else if (isRegRead(baseFc)) begin
            if (countField == 16'h0000 ||
                countField > (asciiMode ? `REGS_MAX_ASCII : `REGS_MAX_BIN)) begin
                checkOk = 1'b0;
            end
        end else if (baseFc == `FC_LOOPBACK) begin
            if (addrField != `DIAG_ECHO_SUB) begin
                checkOk = 1'b0;
            end
        end else if (baseFc == `FC_EXC_STATUS || baseFc == `FC_EVENT_COUNT ||
                     baseFc == `FC_EVENT_LOG) begin
            checkLen = 4'd2;
        end else if (baseFc == `FC_WRITE_REG) begin
            checkLen = wideSel ? 4'd8 : 4'd6;
        end else if (baseFc != `FC_WRITE_COIL) begin
            checkOk = 1'b0;
        end
    end

    // where an incoming reply byte lands in the reply buffer
    reg [9:0] dataIdx;
    reg dataHasCount;
    always @* begin
        dataHasCount = isBitRead(lineFc) || isRegRead(lineFc) || lineFc == `FC_EVENT_LOG;
        dataIdx = rxIdx - (dataHasCount ? 10'd3 : 10'd2);
    end

    // axi4-lite write side; address and data are taken together
    always @(posedge core_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_OKAY;
            asciiMode <= 1'b0;
            wideEnable <= 1'b0;
            request_buffer0 <= 32'h00000000;
            request_buffer1 <= 32'h00000000;
            startReq <= 1'b0;
        end else begin
            startReq <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (axiWrite) begin
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `AXI_OKAY;
                case (s_axi_awaddr)
                    `REG_CTRL: begin
                        if (s_axi_wstrb[0]) begin
                            startReq <= s_axi_wdata[`CTRL_START];
                            asciiMode <= s_axi_wdata[`CTRL_ASCII];
                            wideEnable <= s_axi_wdata[`CTRL_WIDE];
                        end
                    end
                    `REG_STATUS, `REG_WORDS: begin
                    end
                    `REG_REQ0: begin
                        if (s_axi_wstrb[0]) request_buffer0[7:0] <= s_axi_wdata[7:0];
                        if (s_axi_wstrb[1]) request_buffer0[15:8] <= s_axi_wdata[15:8];
                        if (s_axi_wstrb[2]) request_buffer0[23:16] <= s_axi_wdata[23:16];
                        if (s_axi_wstrb[3]) request_buffer0[31:24] <= s_axi_wdata[31:24];
                    end
                    `REG_REQ1: begin
                        if (s_axi_wstrb[0]) request_buffer1[7:0] <= s_axi_wdata[7:0];
                        if (s_axi_wstrb[1]) request_buffer1[15:8] <= s_axi_wdata[15:8];
                        if (s_axi_wstrb[2]) request_buffer1[23:16] <= s_axi_wdata[23:16];
                        if (s_axi_wstrb[3]) request_buffer1[31:24] <= s_axi_wdata[31:24];
                    end
                    default: s_axi_bresp <= `AXI_SLVERR;
                endcase
            end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // axi4-lite read side; reply words need one cycle from the store
    always @(posedge core_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AXI_OKAY;
            rdPending <= 1'b0;
            rdAddrHeld <= 12'h000;
        end else begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (axiRead) begin
                s_axi_arready <= 1'b0;
                rdPending <= 1'b1;
                rdAddrHeld <= s_axi_araddr;
            end else if (s_axi_arvalid && !s_axi_arready && !rdPending && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
            if (rdPending) begin
                rdPending <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `AXI_OKAY;
                s_axi_rdata <= 32'h00000000;
                if (rdAddrHeld[11:10] == 2'b01) begin
                    s_axi_rdata <= {16'h0000, replyWord};
                end else begin
                    case (rdAddrHeld)
                        `REG_CTRL: s_axi_rdata <= {29'h0, wideEnable, asciiMode, 1'b0};
                        `REG_STATUS: s_axi_rdata <= {16'h0, excCode, 3'b000, echoBad,
                                                     excepted, rejected, done, busy};
                        `REG_REQ0: s_axi_rdata <= request_buffer0;
                        `REG_REQ1: s_axi_rdata <= request_buffer1;
                        `REG_WORDS: s_axi_rdata <= {23'h0, wordsStored};
                        default: s_axi_rresp <= `AXI_SLVERR;
                    endcase
                end
            end
        end
    end

    // job sequencer: check, transmit, unpack the reply
    always @(posedge core_clk) begin
        if (rst) begin
            state <= S_IDLE;
            busy <= 1'b0;
            done <= 1'b0;
            rejected <= 1'b0;
            excepted <= 1'b0;
            echoBad <= 1'b0;
            excCode <= 8'h00;
            wordsStored <= 9'd0;
            lineFc <= 8'h00;
            txLen <= 4'd0;
            txIdx <= 4'd0;
            rxIdx <= 10'd0;
            txData <= 8'h00;
            txValid <= 1'b0;
            storeEn <= 1'b0;
            storeLo <= 1'b0;
            storeHi <= 1'b0;
            storeAddr <= 8'h00;
            storeData <= 16'h0000;
        end else begin
            storeEn <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (startReq) begin
                        busy <= 1'b1;
                        done <= 1'b0;
                        rejected <= 1'b0;
                        excepted <= 1'b0;
                        echoBad <= 1'b0;
                        excCode <= 8'h00;
                        wordsStored <= 9'd0;
                        state <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    lineFc <= baseFc;
                    txLen <= checkLen;
                    txIdx <= 4'd0;
                    rxIdx <= 10'd0;
                    if (checkOk) begin
                        // fields pass straight through, high byte first
                        txData <= reqByte(4'd0, request_buffer0, request_buffer1, baseFc);
                        txValid <= 1'b1;
                        state <= S_SEND;
                    end else begin
                        rejected <= 1'b1;
                        done <= 1'b1;
                        busy <= 1'b0;
                        state <= S_IDLE;
                    end
                end
                S_SEND: begin
                    if (txValid && txReady) begin
                        if (txIdx == txLen - 4'd1) begin
                            txValid <= 1'b0;
                            state <= S_RECV;
                        end else begin
                            txIdx <= txIdx + 4'd1;
                            txData <= reqByte(txIdx + 4'd1, request_buffer0, request_buffer1,
                                              lineFc);
                        end
                    end
                end
                S_RECV: begin
                    // bytes ahead of the transmit end are dropped
                    if (rxValid) begin
                        rxIdx <= rxIdx + 10'd1;
                        if (rxIdx == 10'd1 && rxData[`FC_ERROR_BIT]) begin
                            excepted <= 1'b1;
                        end else if (rxIdx == 10'd2 && excepted) begin
                            excCode <= rxData;
                        end else if (lineFc == `FC_LOOPBACK) begin
                            if (rxIdx < 10'd6 &&
                                rxData != reqByte(rxIdx[3:0], request_buffer0, request_buffer1,
                                                  lineFc)) begin
                                echoBad <= 1'b1;
                            end
                        end else if (lineFc == `FC_EXC_STATUS) begin
                            if (rxIdx == 10'd2) begin
                                storeEn <= 1'b1;
                                storeLo <= 1'b0;
                                storeHi <= 1'b1;
                                storeAddr <= 8'h00;
                                storeData <= {rxData, 8'h00};
                                wordsStored <= 9'd1;
                            end
                        end else if ((isBitRead(lineFc) || isRegRead(lineFc) ||
                                      lineFc == `FC_EVENT_COUNT || lineFc == `FC_EVENT_LOG) &&
                                     rxIdx >= (dataHasCount ? 10'd3 : 10'd2) && !dataIdx[9]) begin
                            storeEn <= 1'b1;
                            storeAddr <= dataIdx[8:1];
                            wordsStored <= {1'b0, dataIdx[8:1]} + 9'd1;
                            if (isBitRead(lineFc)) begin
                                // even bytes clear the high half so a lone byte ends as 00h
                                storeLo <= ~dataIdx[0];
                                storeHi <= 1'b1;
                                storeData <= dataIdx[0] ? {rxData, 8'h00} : {8'h00, rxData};
                            end else begin
                                storeLo <= dataIdx[0];
                                storeHi <= ~dataIdx[0];
                                storeData <= {rxData, rxData};
                            end
                        end
                        if (rxLast) begin
                            done <= 1'b1;
                            busy <= 1'b0;
                            state <= S_IDLE;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // modbus_master_request_codec

// ---- verilog/modbus_reply_store.v ----
// reply buffer: 256 words of 16 bits with byte writes and a registered read port
`timescale 1ns/1ps
module modbus_reply_store (
    input wire core_clk,
    input wire wrEn,
    input wire wrLo,
    input wire wrHi,
    input wire [7:0] wrAddr,
    input wire [15:0] wrData,
    input wire [7:0] rdAddr,
    output reg [15:0] rdData
);
    reg [7:0] lowBytes [0:255];
    reg [7:0] highBytes [0:255];

    // no reset on the array: contents are undefined until a reply lands
    always @(posedge core_clk) begin
        if (wrEn && wrLo) begin
            lowBytes[wrAddr] <= wrData[7:0];
        end
        if (wrEn && wrHi) begin
            highBytes[wrAddr] <= wrData[15:8];
        end
        rdData <= {highBytes[rdAddr], lowBytes[rdAddr]};
    end
endmodule // modbus_reply_store
